/* File: pin_mux_pkg.sv */
// shared constants for the pin function multiplexer
package pin_mux_pkg;

  // ----------------------------------------------------------------
  // pin indices
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 16;
  localparam int PIN_A0   = 0;
  localparam int PIN_A1   = 1;
  localparam int PIN_A2   = 2;
  localparam int PIN_A3   = 3;
  localparam int PIN_A6   = 4;
  localparam int PIN_A7   = 5;
  localparam int PIN_B2   = 6;
  localparam int PIN_B3   = 7;
  localparam int PIN_B4   = 8;
  localparam int PIN_B5   = 9;
  localparam int PIN_B6   = 10;
  localparam int PIN_B7   = 11;
  localparam int PIN_C0   = 12;
  localparam int PIN_C1   = 13;
  localparam int PIN_C2   = 14;
  localparam int PIN_C3   = 15;

  // ----------------------------------------------------------------
  // ganged output group, enable bit k drives pin GANG_PIN[k]
  // ----------------------------------------------------------------
  localparam int NUM_GANG = 8;
  localparam int GANG_PIN [NUM_GANG] = '{PIN_B2, PIN_B3, PIN_B4, PIN_B5,
                                         PIN_C0, PIN_C1, PIN_C2, PIN_C3};

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_OPTIONS = 8'h00;
  localparam logic [7:0] OFS_GANG_EN = 8'h04;
  localparam logic [7:0] OFS_OWNER   = 8'h08;
  localparam logic [7:0] OFS_ANALOG  = 8'h0c;

  // ----------------------------------------------------------------
  // system_options_two fields
  // ----------------------------------------------------------------
  localparam int OPT_W        = 5;
  localparam int FLD_T1CH0    = 0;
  localparam int FLD_T1CH1    = 1;
  localparam int FLD_T2CH0    = 2;
  localparam int FLD_T2CH1    = 3;
  localparam int FLD_TWO_WIRE = 4;
  localparam int FLD_LOCKED   = 31;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [OPT_W-1:0]    OPTIONS_RST = 5'h00;
  localparam logic [NUM_GANG-1:0] GANG_RST    = 8'h00;

  // ----------------------------------------------------------------
  // pin owner, in rising priority
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OWN_PORT,
    OWN_TIMER,
    OWN_TWO_WIRE,
    OWN_GANGED,
    OWN_ANALOG
  } owner_t;

endpackage

/* File: pin_sync.sv */
// two-stage synchroniser for pin input levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_ff;

  // only the second stage is visible to logic
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_ff <= '0;
      q       <= '0;
    end
    else
    begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule

/* File: pin_function_priority_mux.sv */
// pin function multiplexer with apb register slave
//
// Overview of operation
// - an option bit moves the two-wire clock and data from port a lines 3 and 2 to port b lines 7 and 6.
// - timer 1 channel pin select bits move channel 0 off port a line 0 and channel 1 off port b line 5.
// - timer 2 channel pin select bits move channel 0 off port a line 1 and channel 1 off port b line 4.
// - eight marked pins form a ganged output group, each enabled by its own bit and driven from port c line 0.
// - a pin enabled for ganged output ignores every digital peripheral that claims it.
// - a ganged pin copies value, drive strength and slew rate of port c line 0, bonded out or not.
// - comparator and converter both enabled on a shared pin both receive the pin level.
`timescale 1ns/1ps
module pin_function_priority_mux #(
  parameter int NPIN = pin_mux_pkg::NUM_PINS
) (
  input  wire logic            CLOCK,
  input  wire logic            SRST,
  // apb slave
  input  wire logic            PSEL,
  input  wire logic            PENABLE,
  input  wire logic            PWRITE,
  input  wire logic [7:0]      PADDR,
  input  wire logic [31:0]     PWDATA,
  output logic                 PREADY,
  output logic      [31:0]     PRDATA,
  output logic                 PSLVERR,
  // plain port function per pin
  input  wire logic [NPIN-1:0] PORT_OUT,
  input  wire logic [NPIN-1:0] PORT_OE,
  input  wire logic [NPIN-1:0] PORT_DRIVE,
  input  wire logic [NPIN-1:0] PORT_SLEW,
  // two-wire serial, open drain
  input  wire logic            TWI_EN,
  input  wire logic            SCL_OE,
  input  wire logic            SDA_OE,
  output logic                 SCL_IN,
  output logic                 SDA_IN,
  // timer channels
  input  wire logic [1:0]      TMR1_EN,
  input  wire logic [1:0]      TMR1_OUT,
  input  wire logic [1:0]      TMR1_OE,
  output logic      [1:0]      TMR1_IN,
  input  wire logic [1:0]      TMR2_EN,
  input  wire logic [1:0]      TMR2_OUT,
  input  wire logic [1:0]      TMR2_OE,
  output logic      [1:0]      TMR2_IN,
  // analog sharing
  input  wire logic [NPIN-1:0] ADC_PIN_EN,
  output logic      [NPIN-1:0] ADC_PIN_IN,
  input  wire logic            ANALOG_COMPARATOR_EN,
  output logic                 ANALOG_COMPARATOR_PLUS_IN,
  output logic                 ANALOG_COMPARATOR_MINUS_IN,
  // package pins
  input  wire logic [NPIN-1:0] PIN_IN,
  output logic      [NPIN-1:0] PIN_OUT,
  output logic      [NPIN-1:0] PIN_OE,
  output logic      [NPIN-1:0] PIN_DRIVE,
  output logic      [NPIN-1:0] PIN_SLEW
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [NPIN-1:0] onehot(input int idx, input logic en);
    logic [NPIN-1:0] v;
    v = '0;
    v[idx] = en;
    return v;
  endfunction

  function automatic logic [NPIN-1:0] gang_expand(
    input logic [pin_mux_pkg::NUM_GANG-1:0] en);
    logic [NPIN-1:0] v;
    v = '0;
    for (int k = 0; k < pin_mux_pkg::NUM_GANG; k++)
      v[pin_mux_pkg::GANG_PIN[k]] = en[k];
    return v;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [pin_mux_pkg::OPT_W-1:0]    options_ff;
  logic                             locked_ff;
  logic [pin_mux_pkg::NUM_GANG-1:0] gang_en_ff;
  logic [NPIN-1:0]                  owner_ff;
  logic [NPIN-1:0]                  analog_ff;
  logic [NPIN-1:0]                  pin_lvl;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire logic hit_opt    = (PADDR == pin_mux_pkg::OFS_OPTIONS);
  wire logic hit_gang   = (PADDR == pin_mux_pkg::OFS_GANG_EN);
  wire logic hit_owner  = (PADDR == pin_mux_pkg::OFS_OWNER);
  wire logic hit_analog = (PADDR == pin_mux_pkg::OFS_ANALOG);
  wire logic hit_any    = hit_opt | hit_gang | hit_owner | hit_analog;
  wire logic setup      = PSEL & ~PENABLE;
  wire logic access     = PSEL & PENABLE;
  wire logic wr_en      = access & PWRITE & hit_any;
  // write-once: later writes to the options word are dropped silently
  wire logic wr_opt     = wr_en & hit_opt & ~locked_ff;
  wire logic wr_gang    = wr_en & hit_gang;

  logic [31:0] rd_word;
  always_comb
  begin
    rd_word = '0;
    if (hit_opt)
    begin
      rd_word[pin_mux_pkg::OPT_W-1:0]    = options_ff;
      rd_word[pin_mux_pkg::FLD_LOCKED]   = locked_ff;
    end
    else if (hit_gang)
      rd_word[pin_mux_pkg::NUM_GANG-1:0] = gang_en_ff;
    else if (hit_owner)
      rd_word[NPIN-1:0] = owner_ff;
    else if (hit_analog)
      rd_word[NPIN-1:0] = analog_ff;
  end

  // zero wait states; an unmapped address answers with an error
  assign PREADY  = 1'b1;
  assign PSLVERR = access & ~hit_any;

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      options_ff <= pin_mux_pkg::OPTIONS_RST;
      locked_ff  <= 1'b0;
      gang_en_ff <= pin_mux_pkg::GANG_RST;
      PRDATA     <= '0;
    end
    else
    begin
      if (wr_opt)
      begin
        options_ff <= PWDATA[pin_mux_pkg::OPT_W-1:0];
        locked_ff  <= 1'b1;
      end
      if (wr_gang)
      begin
        gang_en_ff <= PWDATA[pin_mux_pkg::NUM_GANG-1:0];
      end
      if (setup)
      begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // function locations
  // ----------------------------------------------------------------
  wire logic sel_twi  = options_ff[pin_mux_pkg::FLD_TWO_WIRE];
  wire logic sel_t1c0 = options_ff[pin_mux_pkg::FLD_T1CH0];
  wire logic sel_t1c1 = options_ff[pin_mux_pkg::FLD_T1CH1];
  wire logic sel_t2c0 = options_ff[pin_mux_pkg::FLD_T2CH0];
  wire logic sel_t2c1 = options_ff[pin_mux_pkg::FLD_T2CH1];

  wire integer scl_pin  = sel_twi  ? pin_mux_pkg::PIN_B7 : pin_mux_pkg::PIN_A3;
  wire integer sda_pin  = sel_twi  ? pin_mux_pkg::PIN_B6 : pin_mux_pkg::PIN_A2;
  wire integer t1c0_pin = sel_t1c0 ? pin_mux_pkg::PIN_C0 : pin_mux_pkg::PIN_A0;
  wire integer t1c1_pin = sel_t1c1 ? pin_mux_pkg::PIN_C1 : pin_mux_pkg::PIN_B5;
  wire integer t2c0_pin = sel_t2c0 ? pin_mux_pkg::PIN_A6 : pin_mux_pkg::PIN_A1;
  wire integer t2c1_pin = sel_t2c1 ? pin_mux_pkg::PIN_A7 : pin_mux_pkg::PIN_B4;

  // ----------------------------------------------------------------
  // claim vectors per function
  // ----------------------------------------------------------------
  wire logic [NPIN-1:0] twi_claim = onehot(scl_pin, TWI_EN) | onehot(sda_pin, TWI_EN);
  wire logic [NPIN-1:0] twi_oe    = onehot(scl_pin, TWI_EN & SCL_OE)
                                  | onehot(sda_pin, TWI_EN & SDA_OE);

  wire logic [NPIN-1:0] tmr_claim = onehot(t1c0_pin, TMR1_EN[0]) | onehot(t1c1_pin, TMR1_EN[1])
                                  | onehot(t2c0_pin, TMR2_EN[0]) | onehot(t2c1_pin, TMR2_EN[1]);
  wire logic [NPIN-1:0] tmr_out   = onehot(t1c0_pin, TMR1_EN[0] & TMR1_OUT[0])
                                  | onehot(t1c1_pin, TMR1_EN[1] & TMR1_OUT[1])
                                  | onehot(t2c0_pin, TMR2_EN[0] & TMR2_OUT[0])
                                  | onehot(t2c1_pin, TMR2_EN[1] & TMR2_OUT[1]);
  wire logic [NPIN-1:0] tmr_oe    = onehot(t1c0_pin, TMR1_EN[0] & TMR1_OE[0])
                                  | onehot(t1c1_pin, TMR1_EN[1] & TMR1_OE[1])
                                  | onehot(t2c0_pin, TMR2_EN[0] & TMR2_OE[0])
                                  | onehot(t2c1_pin, TMR2_EN[1] & TMR2_OE[1]);

  wire logic [NPIN-1:0] gang_claim = gang_expand(gang_en_ff);

  // both analog users only observe the pin, so neither excludes the other
  wire logic [NPIN-1:0] analog_comparator_claim = onehot(pin_mux_pkg::PIN_A0, ANALOG_COMPARATOR_EN)
                                   | onehot(pin_mux_pkg::PIN_A1, ANALOG_COMPARATOR_EN);
  wire logic [NPIN-1:0] ana_claim  = ADC_PIN_EN | analog_comparator_claim;

  // master settings come from the port c line 0 port logic, which exists even unbonded
  wire logic mst_out   = PORT_OUT[pin_mux_pkg::PIN_C0];
  wire logic mst_drive = PORT_DRIVE[pin_mux_pkg::PIN_C0];
  wire logic mst_slew  = PORT_SLEW[pin_mux_pkg::PIN_C0];

  // ----------------------------------------------------------------
  // per-pin priority resolution
  // ----------------------------------------------------------------
  pin_mux_pkg::owner_t owner [NPIN];
  logic [NPIN-1:0]     nxt_pin_out;
  logic [NPIN-1:0]     nxt_pin_oe;
  logic [NPIN-1:0]     nxt_pin_drive;
  logic [NPIN-1:0]     nxt_pin_slew;
  logic [NPIN-1:0]     nxt_owner;
  logic [NPIN-1:0]     nxt_analog;

  always_comb
  begin
    for (int i = 0; i < NPIN; i++)
    begin
      owner[i] = pin_mux_pkg::OWN_PORT;
      if (tmr_claim[i])
        owner[i] = pin_mux_pkg::OWN_TIMER;
      if (twi_claim[i])
        owner[i] = pin_mux_pkg::OWN_TWO_WIRE;
      if (gang_claim[i])
        owner[i] = pin_mux_pkg::OWN_GANGED;
      if (ana_claim[i])
        owner[i] = pin_mux_pkg::OWN_ANALOG;
      nxt_owner[i]  = (owner[i] != pin_mux_pkg::OWN_PORT);
      nxt_analog[i] = (owner[i] == pin_mux_pkg::OWN_ANALOG);
    end
  end

  always_comb
  begin
    for (int i = 0; i < NPIN; i++)
    begin
      case (owner[i])
        pin_mux_pkg::OWN_PORT:
        begin
          nxt_pin_out[i]   = PORT_OUT[i];
          nxt_pin_oe[i]    = PORT_OE[i];
          nxt_pin_drive[i] = PORT_DRIVE[i];
          nxt_pin_slew[i]  = PORT_SLEW[i];
        end
        pin_mux_pkg::OWN_TIMER:
        begin
          nxt_pin_out[i]   = tmr_out[i];
          nxt_pin_oe[i]    = tmr_oe[i];
          nxt_pin_drive[i] = PORT_DRIVE[i];
          nxt_pin_slew[i]  = PORT_SLEW[i];
        end
        pin_mux_pkg::OWN_TWO_WIRE:
        begin
          // open drain: only ever pulls low
          nxt_pin_out[i]   = 1'b0;
          nxt_pin_oe[i]    = twi_oe[i];
          nxt_pin_drive[i] = PORT_DRIVE[i];
          nxt_pin_slew[i]  = PORT_SLEW[i];
        end
        pin_mux_pkg::OWN_GANGED:
        begin
          nxt_pin_out[i]   = mst_out;
          nxt_pin_oe[i]    = 1'b1;
          nxt_pin_drive[i] = mst_drive;
          nxt_pin_slew[i]  = mst_slew;
        end
        default:
        begin
          // analog owner: digital driver off so the analog input sees the pad
          nxt_pin_out[i]   = 1'b0;
          nxt_pin_oe[i]    = 1'b0;
          nxt_pin_drive[i] = 1'b0;
          nxt_pin_slew[i]  = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pad outputs and owner status
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      PIN_OUT   <= '0;
      PIN_OE    <= '0;
      PIN_DRIVE <= '0;
      PIN_SLEW  <= '0;
      owner_ff  <= '0;
      analog_ff <= '0;
    end
    else
    begin
      PIN_OUT   <= nxt_pin_out;
      PIN_OE    <= nxt_pin_oe;
      PIN_DRIVE <= nxt_pin_drive;
      PIN_SLEW  <= nxt_pin_slew;
      owner_ff  <= nxt_owner;
      analog_ff <= nxt_analog;
    end
  end

  // ----------------------------------------------------------------
  // inputs back to the peripherals
  // ----------------------------------------------------------------
  pin_sync #(.WIDTH (NPIN)) u_sync (
    .clk  (CLOCK),
    .srst (SRST),
    .d    (PIN_IN),
    .q    (pin_lvl)
  );

  // pad level reaches a module only where that module claims the pin, even where a higher-priority owner wins it
  wire logic [NPIN-1:0] sel_lvl = pin_lvl & twi_claim;
  wire logic [NPIN-1:0] tmr_lvl = pin_lvl & tmr_claim;

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      SCL_IN        <= 1'b1;
      SDA_IN        <= 1'b1;
      TMR1_IN       <= '0;
      TMR2_IN       <= '0;
      ADC_PIN_IN    <= '0;
      ANALOG_COMPARATOR_PLUS_IN  <= 1'b0;
      ANALOG_COMPARATOR_MINUS_IN <= 1'b0;
    end
    else
    begin
      SCL_IN        <= ~TWI_EN | sel_lvl[scl_pin];
      SDA_IN        <= ~TWI_EN | sel_lvl[sda_pin];
      TMR1_IN       <= {tmr_lvl[t1c1_pin], tmr_lvl[t1c0_pin]};
      TMR2_IN       <= {tmr_lvl[t2c1_pin], tmr_lvl[t2c0_pin]};
      ADC_PIN_IN    <= pin_lvl & ADC_PIN_EN;
      ANALOG_COMPARATOR_PLUS_IN  <= ANALOG_COMPARATOR_EN & pin_lvl[pin_mux_pkg::PIN_A0];
      ANALOG_COMPARATOR_MINUS_IN <= ANALOG_COMPARATOR_EN & pin_lvl[pin_mux_pkg::PIN_A1];
    end
  end

endmodule

/* File: pin_mux_props.sv */
// concurrent checks of pin ownership for the pin multiplexer
`timescale 1ns/1ps
module pin_mux_props #(
  parameter int NPIN = 16
) (
  input wire logic            CLOCK,
  input wire logic            SRST,
  input wire logic            PSEL,
  input wire logic            PENABLE,
  input wire logic            PWRITE,
  input wire logic [7:0]      PADDR,
  input wire logic [31:0]     PWDATA,
  input wire logic [NPIN-1:0] PORT_OUT,
  input wire logic [NPIN-1:0] PORT_DRIVE,
  input wire logic [NPIN-1:0] PORT_SLEW,
  input wire logic            TWI_EN,
  input wire logic            SCL_OE,
  input wire logic [1:0]      TMR1_EN,
  input wire logic [1:0]      TMR1_OUT,
  input wire logic [1:0]      TMR2_EN,
  input wire logic [1:0]      TMR2_OUT,
  input wire logic [NPIN-1:0] ADC_PIN_EN,
  input wire logic            ANALOG_COMPARATOR_EN,
  input wire logic [NPIN-1:0] PIN_IN,
  input wire logic [NPIN-1:0] ADC_PIN_IN,
  input wire logic            ANALOG_COMPARATOR_PLUS_IN,
  input wire logic [NPIN-1:0] PIN_OUT,
  input wire logic [NPIN-1:0] PIN_OE,
  input wire logic [NPIN-1:0] PIN_DRIVE,
  input wire logic [NPIN-1:0] PIN_SLEW
);
  // ----
  // shadow registers, rebuilt from apb writes so the checks need no internals
  // ----
  logic [4:0] opt_ff;
  logic       lock_ff;
  logic [7:0] gang_ff;
  wire        wr_now  = PSEL & PENABLE & PWRITE;
  wire        twi_home = TWI_EN & ~opt_ff[4] & ~ADC_PIN_EN[3];
  wire        t1_home = TMR1_EN[0] & ~opt_ff[0] & ~ADC_PIN_EN[0] & ~ANALOG_COMPARATOR_EN;
  wire        t1_away = TMR1_EN[1] & opt_ff[1] & ~gang_ff[5] & ~ADC_PIN_EN[13];
  wire        t2_home = TMR2_EN[0] & ~opt_ff[2] & ~ADC_PIN_EN[1] & ~ANALOG_COMPARATOR_EN;
  wire        g_b2    = gang_ff[0] & ~ADC_PIN_EN[6];
  wire        g_b5    = gang_ff[3] & TMR1_EN[1] & ~ADC_PIN_EN[9];
  wire        g_c3    = gang_ff[7] & ~ADC_PIN_EN[15];

  always_ff @(posedge CLOCK)
    if (SRST)
    begin
      opt_ff  <= 5'h00;
      lock_ff <= 1'b0;
      gang_ff <= 8'h00;
    end
    else if (wr_now)
    begin
      if (PADDR == 8'h00 && !lock_ff)
      begin
        opt_ff  <= PWDATA[4:0];
        lock_ff <= 1'b1;
      end
      if (PADDR == 8'h04)
        gang_ff <= PWDATA[7:0];
    end

  // ----
  // assertions
  // ----
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);

  twi_home_a: assert property (!$past(SRST) && $past(twi_home)
    |-> PIN_OE[3] == $past(SCL_OE)) else $error("two-wire clock not on its reset pin");
  tmr1_home_a: assert property (!$past(SRST) && $past(t1_home)
    |-> PIN_OUT[0] == $past(TMR1_OUT[0])) else $error("timer 1 channel 0 not on its reset pin");
  tmr1_moved_a: assert property (!$past(SRST) && $past(t1_away)
    |-> PIN_OUT[13] == $past(TMR1_OUT[1])) else $error("timer 1 channel 1 not on its moved pin");
  tmr2_home_a: assert property (!$past(SRST) && $past(t2_home)
    |-> PIN_OUT[1] == $past(TMR2_OUT[0])) else $error("timer 2 channel 0 not on its reset pin");
  gang_group_a: assert property (!$past(SRST) && $past(g_b2)
    |-> PIN_OE[6] && PIN_OUT[6] == $past(PORT_OUT[12])) else $error("ganged pin not driven from master");
  gang_wins_a: assert property (!$past(SRST) && $past(g_b5)
    |-> PIN_OUT[9] == $past(PORT_OUT[12])) else $error("timer beat the ganged output");
  gang_copy_a: assert property (!$past(SRST) && $past(g_c3)
    |-> PIN_DRIVE[15] == $past(PORT_DRIVE[12]) && PIN_SLEW[15] == $past(PORT_SLEW[12]))
    else $error("ganged pin drive or slew differs from master");
  shared_analog_a: assert property ((ANALOG_COMPARATOR_EN && ADC_PIN_EN[0] && $stable(PIN_IN[0]))[*5]
    |-> ANALOG_COMPARATOR_PLUS_IN == PIN_IN[0] && ADC_PIN_IN[0] == PIN_IN[0]) else $error("analog users not both fed");
  analog_wins_a: assert property (!$past(SRST) && $past(ADC_PIN_EN[0])
    |-> !PIN_OE[0]) else $error("digital driver on an analog pin");
endmodule

bind pin_function_priority_mux pin_mux_props #(.NPIN(NPIN)) props_i (
  .CLOCK(CLOCK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PORT_OUT(PORT_OUT), .PORT_DRIVE(PORT_DRIVE), .PORT_SLEW(PORT_SLEW),
  .TWI_EN(TWI_EN), .SCL_OE(SCL_OE), .TMR1_EN(TMR1_EN), .TMR1_OUT(TMR1_OUT), .TMR2_EN(TMR2_EN),
  .TMR2_OUT(TMR2_OUT), .ADC_PIN_EN(ADC_PIN_EN), .ANALOG_COMPARATOR_EN(ANALOG_COMPARATOR_EN), .PIN_IN(PIN_IN),
  .ADC_PIN_IN(ADC_PIN_IN), .ANALOG_COMPARATOR_PLUS_IN(ANALOG_COMPARATOR_PLUS_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
  .PIN_DRIVE(PIN_DRIVE), .PIN_SLEW(PIN_SLEW)
);

/* File: pad_model.sv */
// pad and board model feeding the pin input levels
`timescale 1ns/1ps
module pad_model (
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] ext_level,
  output logic      [15:0] pin_in
);
  // ----
  // a driven pad reads back its own level, an idle one shows the board level
  // ----
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

/* File: test_pin_function_priority_mux.sv */
// self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
module test_pin_function_priority_mux;
  logic        clock, srst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        twi_en, scl_oe, sda_oe, scl_in, sda_in, analog_comparator_en, analog_comparator_plus, analog_comparator_minus;
  logic [1:0]  t1_en, t1_out, t1_oe, t1_in, t2_en, t2_out, t2_oe, t2_in;
  logic [15:0] port_out, port_oe, port_drive, port_slew, adc_en, adc_in, ext, pin_in;
  logic [15:0] pin_out, pin_oe, pin_drive, pin_slew;
  int          miscompares = 0;
  int          cmp_count = 0;

  pin_function_priority_mux dut (
    .CLOCK(clock), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .PORT_OUT(port_out),
    .PORT_OE(port_oe), .PORT_DRIVE(port_drive), .PORT_SLEW(port_slew), .TWI_EN(twi_en),
    .SCL_OE(scl_oe), .SDA_OE(sda_oe), .SCL_IN(scl_in), .SDA_IN(sda_in), .TMR1_EN(t1_en),
    .TMR1_OUT(t1_out), .TMR1_OE(t1_oe), .TMR1_IN(t1_in), .TMR2_EN(t2_en), .TMR2_OUT(t2_out),
    .TMR2_OE(t2_oe), .TMR2_IN(t2_in), .ADC_PIN_EN(adc_en), .ADC_PIN_IN(adc_in), .ANALOG_COMPARATOR_EN(analog_comparator_en),
    .ANALOG_COMPARATOR_PLUS_IN(analog_comparator_plus), .ANALOG_COMPARATOR_MINUS_IN(analog_comparator_minus), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .PIN_DRIVE(pin_drive), .PIN_SLEW(pin_slew)
  );
  pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----
  // shared tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // one transfer; the extra edge at the end keeps back-to-back calls from re-driving psel in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      miscompares++;
      finish_test();
    end
    @(posedge clock);
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_regs();
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk({rd[31:1], err}, 32'h0);
    end
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[31:1], err}, 32'h1);
    apb(1'b1, 8'h08, 32'hffff_ffff);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_default();
    port_out <= 16'hffff;
    port_oe  <= 16'hffff;
    ext      <= 16'ha5a5;
    t1_en    <= 2'b11;
    t1_oe    <= 2'b10;
    t2_en    <= 2'b11;
    twi_en   <= 1'b1;
    sda_oe   <= 1'b1;
    tick(6);
    chk({pin_out[0], pin_out[9]}, 32'h0);
    chk({pin_out[1], pin_out[8]}, 32'h0);
    chk({pin_oe[3], pin_oe[2], scl_in, sda_in}, 32'h4);
    chk({t1_in, t2_in}, 32'h6);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0000_030f);
    $display("test default pins done");
  endtask

  task automatic t_gang();
    port_drive <= 16'h1000;
    port_slew  <= 16'h1000;
    apb(1'b1, 8'h04, 32'hff);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'hff);
    tick(2);
    for (int k = 0; k < pin_mux_pkg::NUM_GANG; k++)
      chk({pin_out[pin_mux_pkg::GANG_PIN[k]], pin_oe[pin_mux_pkg::GANG_PIN[k]],
           pin_drive[pin_mux_pkg::GANG_PIN[k]], pin_slew[pin_mux_pkg::GANG_PIN[k]]}, 32'hf);
    apb(1'b1, 8'h04, 32'h0);
    tick(2);
    chk({pin_out[8], pin_out[9], pin_drive[6]}, 32'h0);
    $display("test ganged output done");
  endtask

  // options are write-once, so this runs after every default-location check
  task automatic t_options();
    apb(1'b1, 8'h00, 32'h1f);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h8000_001f);
    tick(2);
    chk({pin_out[12], pin_out[13], pin_out[4], pin_out[5]}, 32'h0);
    chk({pin_out[0], pin_out[9], pin_out[1], pin_out[8]}, 32'hf);
    chk({pin_oe[11], pin_oe[10], pin_oe[3], pin_oe[2]}, 32'h7);
    $display("test relocation done");
  endtask

  task automatic t_analog();
    analog_comparator_en <= 1'b1;
    adc_en  <= 16'h0001;
    for (int v = 0; v < 2; v++)
    begin
      ext[1:0] <= {~v[0], v[0]};
      tick(6);
      chk({analog_comparator_plus, adc_in[0], analog_comparator_minus}, {29'h0, v[0], v[0], ~v[0]});
    end
    chk(pin_oe[0], 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h3);
    $display("test analog sharing done");
  endtask

  initial
  begin
    {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {twi_en, scl_oe, sda_oe, analog_comparator_en, t1_en, t1_out, t1_oe, t2_en, t2_out, t2_oe} = 16'h0;
    {port_out, port_oe, port_drive, port_slew, adc_en, ext} = 96'h0;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_default();
    t_gang();
    t_options();
    t_analog();
    finish_test();
  end
endmodule
